// file: logic/aow_output_word_cfg.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - Retimer source picks serial or internal clocks
// - Reserved bits read zero, never written
// - Strobe source register at 4h, resets zero
// - Output word register at 5h, resets zero
// - Ready suppress bit masks ready output
// - Strobe keeps running while ready masked
// - Byte order bit selects AA or AB
// - Test pattern bit replaces results with constant
// - Justify bit aligns narrow results left/right
// - Averaging depth gives none, two or four
// - Averaging register at 6h, resets zero
// - Reference offset register at 7h, resets zero
// - Protocols 010b/011b are clock retimer modes
// - Protocols 1xx select parallel byte mode
module aow_output_word_cfg #(
  parameter int RES_BITS = aow_pkg::RES_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Conversion results
  input wire logic [15:0] conv_a,
  input wire logic [15:0] conv_b,
  input wire logic conv_valid,
  // Link framing and serial clock pin
  input wire logic frame_start,
  input wire logic sclk_pin,
  // Output path
  output logic [31:0] data_word,
  output logic word_valid,
  output logic [15:0] byte_pair,
  output logic parallel_mode,
  output logic ready_out,
  output logic strobe_out
);
  localparam int PAD = aow_pkg::SAMPLE_BITS - RES_BITS;

  typedef struct packed {
    aow_pkg::aow_cfg_t cfg;
    aow_pkg::aow_cfg_t act;
    logic [7:0] rdata;
    logic sclk_s1;
    logic sclk_s2;
    logic [1:0] div;
    logic strobe;
    logic [31:0] word;
    logic word_valid;
    logic [15:0] pair;
    logic par;
    logic ready;
    logic ready_out;
  } aow_top_state_t;

  aow_top_state_t q, n;
  aow_avg_if av_if[2] ();
  logic [15:0] res_a, res_b;
  logic retimer_mode;
  logic [1:0] src;

  function automatic logic [15:0] aow_align(input logic [15:0] v,
                                            input logic right);
    logic [15:0] r;
    r = v;
    if (!right) begin
      r = 16'(v << PAD);
    end
    return r;
  endfunction

  // One averager per converter channel
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_avg
      assign av_if[ch].depth = q.act.avg[aow_pkg::DEPTH_MSB:0];
      assign av_if[ch].in_valid = conv_valid;
      assign av_if[ch].in_data = (ch == 0) ? conv_a : conv_b;
      aow_averager u_avg (
        .clk(clk),
        .reset(reset),
        .av(av_if[ch])
      );
    end
  endgenerate

  assign res_a = aow_align(av_if[0].out_data,
                           q.act.word[aow_pkg::BIT_RIGHT]);
  assign res_b = aow_align(av_if[1].out_data,
                           q.act.word[aow_pkg::BIT_RIGHT]);

  always_comb begin
    n = q;
    n.rdata = 8'h00;
    n.word_valid = 1'b0;
    n.sclk_s1 = sclk_pin;
    n.sclk_s2 = q.sclk_s1;
    n.div = q.div + 2'd1;
    retimer_mode = 1'b0;
    src = q.act.strobe[aow_pkg::SRC_MSB:0];

    // Writes keep reserved bits at zero
    if (reg_wr) begin
      unique case (reg_addr)
        aow_pkg::OFF_PROTOCOL:
          n.cfg.protocol = reg_wdata & aow_pkg::MASK_PROTOCOL;
        aow_pkg::OFF_STROBE:
          n.cfg.strobe = reg_wdata & aow_pkg::MASK_STROBE;
        aow_pkg::OFF_WORD:
          n.cfg.word = reg_wdata & aow_pkg::MASK_WORD;
        aow_pkg::OFF_AVG:
          n.cfg.avg = reg_wdata & aow_pkg::MASK_AVG;
        aow_pkg::OFF_REFOFS:
          n.cfg.refofs = reg_wdata & aow_pkg::MASK_REFOFS;
        default: ;
      endcase
    end

    // Unmapped offsets read zero
    if (reg_rd) begin
      unique case (reg_addr)
        aow_pkg::OFF_PROTOCOL: n.rdata = q.cfg.protocol;
        aow_pkg::OFF_STROBE: n.rdata = q.cfg.strobe;
        aow_pkg::OFF_WORD: n.rdata = q.cfg.word;
        aow_pkg::OFF_AVG: n.rdata = q.cfg.avg;
        aow_pkg::OFF_REFOFS: n.rdata = q.cfg.refofs;
        default: n.rdata = 8'h00;
      endcase
    end

    // Settings only move into use between frames, never mid-word
    if (frame_start) begin
      n.act = q.cfg;
      n.ready = 1'b0;
    end

    retimer_mode = q.act.protocol[aow_pkg::PROTO_MSB:aow_pkg::PROTO_LSB]
                   == aow_pkg::PROTO_RETIMER_SDR ||
                   q.act.protocol[aow_pkg::PROTO_MSB:aow_pkg::PROTO_LSB]
                   == aow_pkg::PROTO_RETIMER_DDR;
    n.par = q.act.protocol[aow_pkg::PROTO_MSB];

    // Internal clock is modelled at the system clock rate
    unique case (src)
      aow_pkg::SRC_SERIAL: n.strobe = q.sclk_s2;
      aow_pkg::SRC_INT: n.strobe = ~q.strobe;
      aow_pkg::SRC_INT_DIV2:
        n.strobe = q.div[0] ? ~q.strobe : q.strobe;
      aow_pkg::SRC_INT_DIV4:
        n.strobe = (q.div == 2'd3) ? ~q.strobe : q.strobe;
    endcase
    // Strobe ignores the ready mask on purpose
    if (!retimer_mode) begin
      n.strobe = 1'b0;
    end

    if (av_if[0].out_valid) begin
      n.word_valid = 1'b1;
      n.ready = 1'b1;
      if (q.act.word[aow_pkg::BIT_PATTERN]) begin
        n.word = aow_pkg::TEST_PATTERN;
      end else begin
        n.word = {res_a, res_b};
      end
      if (q.act.word[aow_pkg::BIT_BYTE_ORDER]) begin
        n.pair = {n.word[31:24], n.word[15:8]};
      end else begin
        n.pair = n.word[31:16];
      end
    end
    n.ready_out = n.ready & ~n.act.word[aow_pkg::BIT_READY_MASK];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.cfg.protocol <= aow_pkg::RST_PROTOCOL;
      q.cfg.strobe <= aow_pkg::RST_STROBE;
      q.cfg.word <= aow_pkg::RST_WORD;
      q.cfg.avg <= aow_pkg::RST_AVG;
      q.cfg.refofs <= aow_pkg::RST_REFOFS;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign data_word = q.word;
  assign word_valid = q.word_valid;
  assign byte_pair = q.pair;
  assign parallel_mode = q.par;
  assign ready_out = q.ready_out;
  assign strobe_out = q.strobe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_retimer_int;
    retimer_mode && src == aow_pkg::SRC_INT;
  endsequence
  sequence s_masked_int;
    s_retimer_int ##0 q.act.word[aow_pkg::BIT_READY_MASK];
  endsequence
  sequence s_result_pattern;
    av_if[0].out_valid && q.act.word[aow_pkg::BIT_PATTERN];
  endsequence

  chk_strobe_int_src: assert property (
    s_retimer_int ##1 s_retimer_int |-> strobe_out != $past(strobe_out))
    else $error("strobe not following internal clock");

  // Checked step by step so a source change between frames cannot trip it
  chk_strobe_div4: assert property (
    retimer_mode && src == aow_pkg::SRC_INT_DIV4 && q.div != 2'd3
    |=> $stable(strobe_out))
    else $error("strobe divide by four wrong");

  chk_strobe_div4_step: assert property (
    retimer_mode && src == aow_pkg::SRC_INT_DIV4 && q.div == 2'd3
    |=> $changed(strobe_out))
    else $error("strobe divide by four missed step");

  chk_strobe_div2: assert property (
    retimer_mode && src == aow_pkg::SRC_INT_DIV2 && !q.div[0]
    |=> $stable(strobe_out))
    else $error("strobe divide by two wrong");

  chk_strobe_serial: assert property (
    retimer_mode && src == aow_pkg::SRC_SERIAL
    |=> strobe_out == $past(q.sclk_s2))
    else $error("strobe not following serial clock");

  chk_strobe_off: assert property (
    !retimer_mode |=> !strobe_out)
    else $error("strobe running outside retimer modes");

  chk_reserved_zero: assert property (
    reg_rd && reg_addr == aow_pkg::OFF_WORD
    |=> reg_rdata[7:6] == 2'b00 && reg_rdata[3:2] == 2'b00)
    else $error("reserved bits read nonzero");

  chk_strobe_reset: assert property (
    $fell(reset) |-> q.cfg.strobe == aow_pkg::RST_STROBE)
    else $error("strobe source not reset");

  chk_word_reg_read: assert property (
    reg_rd && reg_addr == aow_pkg::OFF_WORD
    |=> reg_rdata == $past(q.cfg.word))
    else $error("output word register readback wrong");

  chk_ready_masked: assert property (
    q.act.word[aow_pkg::BIT_READY_MASK] |-> !ready_out)
    else $error("ready not masked");

  chk_strobe_unmasked: assert property (
    s_masked_int ##1 s_masked_int |-> $changed(strobe_out))
    else $error("strobe stopped by ready mask");

  chk_byte_order: assert property (
    av_if[0].out_valid && q.act.word[aow_pkg::BIT_BYTE_ORDER]
    |=> byte_pair == {data_word[31:24], data_word[15:8]})
    else $error("byte order AB wrong");

  chk_test_pattern: assert property (
    s_result_pattern |=> word_valid && data_word == aow_pkg::TEST_PATTERN)
    else $error("test pattern missing");

  chk_avg_reg_read: assert property (
    reg_rd && reg_addr == aow_pkg::OFF_AVG
    |=> reg_rdata == {6'h00, $past(q.cfg.avg[1:0])})
    else $error("averaging register readback wrong");

  chk_refofs_read: assert property (
    reg_rd && reg_addr == aow_pkg::OFF_REFOFS
    |=> reg_rdata[7:1] == 7'h00)
    else $error("offset register reserved bits set");

  chk_parallel_mode: assert property (
    q.act.protocol[aow_pkg::PROTO_MSB] |=> parallel_mode)
    else $error("parallel byte mode not selected");

  chk_frame_latch: assert property (
    !frame_start |=> $stable(q.act))
    else $error("settings changed mid-frame");

  chk_word_reset: assert property (
    $fell(reset) |-> q.cfg.word == aow_pkg::RST_WORD)
    else $error("output word register not reset");

  chk_avg_reset: assert property (
    $fell(reset) |-> q.cfg.avg == aow_pkg::RST_AVG)
    else $error("averaging register not reset");

  chk_refofs_reset: assert property (
    $fell(reset) |-> q.cfg.refofs == aow_pkg::RST_REFOFS)
    else $error("offset register not reset");

  // A frame start in the same cycle may bring in a new mask
  chk_ready_unmasked: assert property (
    av_if[0].out_valid && !q.act.word[aow_pkg::BIT_READY_MASK] && !frame_start
    |=> ready_out)
    else $error("ready not driven while unmasked");

  chk_align_left: assert property (
    av_if[0].out_valid && !q.act.word[aow_pkg::BIT_PATTERN]
    && !q.act.word[aow_pkg::BIT_RIGHT]
    |=> data_word[31:16] == 16'($past(av_if[0].out_data) << PAD))
    else $error("result not left aligned");

  chk_align_right: assert property (
    av_if[0].out_valid && !q.act.word[aow_pkg::BIT_PATTERN]
    && q.act.word[aow_pkg::BIT_RIGHT]
    |=> data_word[15:0] == $past(av_if[1].out_data))
    else $error("result not right aligned");

  chk_byte_order_aa: assert property (
    av_if[0].out_valid && !q.act.word[aow_pkg::BIT_BYTE_ORDER]
    |=> byte_pair == data_word[31:16])
    else $error("byte order AA wrong");
endmodule

// file: logic/aow_pkg.sv
package aow_pkg;
  // Register offsets
  localparam logic [3:0] OFF_PROTOCOL = 4'h2;
  localparam logic [3:0] OFF_STROBE = 4'h4;
  localparam logic [3:0] OFF_WORD = 4'h5;
  localparam logic [3:0] OFF_AVG = 4'h6;
  localparam logic [3:0] OFF_REFOFS = 4'h7;

  // Writable bits; all others are reserved and read zero
  localparam logic [7:0] MASK_PROTOCOL = 8'h73;
  localparam logic [7:0] MASK_STROBE = 8'h03;
  localparam logic [7:0] MASK_WORD = 8'h33;
  localparam logic [7:0] MASK_AVG = 8'h03;
  localparam logic [7:0] MASK_REFOFS = 8'h01;

  // Reset values
  localparam logic [7:0] RST_PROTOCOL = 8'h00;
  localparam logic [7:0] RST_STROBE = 8'h00;
  localparam logic [7:0] RST_WORD = 8'h00;
  localparam logic [7:0] RST_AVG = 8'h00;
  localparam logic [7:0] RST_REFOFS = 8'h00;

  // Field positions
  localparam int BIT_READY_MASK = 5;
  localparam int BIT_BYTE_ORDER = 4;
  localparam int BIT_PATTERN = 1;
  localparam int BIT_RIGHT = 0;
  localparam int PROTO_MSB = 6;
  localparam int PROTO_LSB = 4;
  localparam int SRC_MSB = 1;
  localparam int DEPTH_MSB = 1;

  // Encodings
  localparam logic [2:0] PROTO_RETIMER_SDR = 3'h2;
  localparam logic [2:0] PROTO_RETIMER_DDR = 3'h3;
  localparam logic [1:0] SRC_SERIAL = 2'h0;
  localparam logic [1:0] SRC_INT = 2'h1;
  localparam logic [1:0] SRC_INT_DIV2 = 2'h2;
  localparam logic [1:0] SRC_INT_DIV4 = 2'h3;
  localparam logic [1:0] AVG_TWO = 2'h2;
  localparam logic [1:0] AVG_FOUR = 2'h3;
  localparam logic [31:0] TEST_PATTERN = 32'hA55A_A55A;

  // Sample layout
  localparam int RES_BITS = 16;
  localparam int SAMPLE_BITS = 16;

  typedef struct packed {
    logic [7:0] protocol;
    logic [7:0] strobe;
    logic [7:0] word;
    logic [7:0] avg;
    logic [7:0] refofs;
  } aow_cfg_t;
endpackage

// file: logic/aow_avg_if.sv
`timescale 1ns/1ps
interface aow_avg_if;
  logic [1:0] depth;
  logic in_valid;
  logic [aow_pkg::SAMPLE_BITS-1:0] in_data;
  logic out_valid;
  logic [aow_pkg::SAMPLE_BITS-1:0] out_data;

  modport avg (
    input depth,
    input in_valid,
    input in_data,
    output out_valid,
    output out_data
  );
  modport user (
    output depth,
    output in_valid,
    output in_data,
    input out_valid,
    input out_data
  );
endinterface

// file: logic/aow_averager.sv
`timescale 1ns/1ps
module aow_averager (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sample stream
  aow_avg_if.avg av
);
  typedef struct packed {
    logic [aow_pkg::SAMPLE_BITS+1:0] acc;
    logic [1:0] cnt;
    logic vld;
    logic [aow_pkg::SAMPLE_BITS-1:0] mean;
  } aow_avg_state_t;

  aow_avg_state_t q, n;
  logic [aow_pkg::SAMPLE_BITS+1:0] sum;

  always_comb begin
    n = q;
    n.vld = 1'b0;
    sum = q.acc + {2'b00, av.in_data};
    if (av.in_valid) begin
      // Depth 00 and 01 pass each sample straight through
      unique case (av.depth)
        aow_pkg::AVG_TWO: begin
          if (q.cnt[0]) begin
            n.mean = sum[aow_pkg::SAMPLE_BITS:1];
            n.vld = 1'b1;
            n.acc = '0;
            n.cnt = 2'd0;
          end else begin
            n.acc = sum;
            n.cnt = 2'd1;
          end
        end
        aow_pkg::AVG_FOUR: begin
          if (q.cnt == 2'd3) begin
            n.mean = sum[aow_pkg::SAMPLE_BITS+1:2];
            n.vld = 1'b1;
            n.acc = '0;
            n.cnt = 2'd0;
          end else begin
            n.acc = sum;
            n.cnt = q.cnt + 2'd1;
          end
        end
        default: begin
          n.mean = av.in_data;
          n.vld = 1'b1;
          n.acc = '0;
          n.cnt = 2'd0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign av.out_valid = q.vld;
  assign av.out_data = q.mean;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_two_in;
    av.in_valid && av.depth == aow_pkg::AVG_TWO && !q.cnt[0];
  endsequence
  sequence s_two_second;
    av.in_valid && av.depth == aow_pkg::AVG_TWO && q.cnt[0];
  endsequence

  chk_avg_pass_through: assert property (
    av.in_valid && av.depth < aow_pkg::AVG_TWO
    |=> av.out_valid && av.out_data == $past(av.in_data))
    else $error("sample not passed through");

  chk_avg_two_first: assert property (
    s_two_in |=> !av.out_valid)
    else $error("mean of two produced early");

  chk_avg_two_pair: assert property (
    s_two_second |=> av.out_valid)
    else $error("mean of two not produced");
endmodule

// file: verif/aow_host_model.sv
`timescale 1ns/1ps
module aow_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bench request
  input wire logic frame_req,
  // Device output path
  input wire logic word_valid,
  input wire logic [31:0] data_word,
  input wire logic [15:0] byte_pair,
  // Link side
  output logic frame_start,
  output logic sclk_pin,
  output logic [31:0] last_word,
  output logic [15:0] last_pair,
  output int n_words
);
  int run;
  // Serial clock runs only inside a frame, idles low elsewhere
  always @(posedge clk) begin
    frame_start <= frame_req && !reset;
    if (reset) begin
      run <= 0;
      sclk_pin <= 1'b0;
      n_words <= 0;
    end else begin
      if (frame_start) begin
        run <= 64;
      end else if (run > 0) begin
        run <= run - 1;
      end
      if (run > 0 && run % 4 == 0) begin
        sclk_pin <= !sclk_pin;
      end else if (run == 0) begin
        sclk_pin <= 1'b0;
      end
      if (word_valid) begin
        last_word <= data_word;
        last_pair <= byte_pair;
        n_words <= n_words + 1;
      end
    end
  end
endmodule

// file: verif/aow_output_word_cfg_tb.sv
`timescale 1ns/1ps
module aow_output_word_cfg_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [15:0] conv_a = 16'h0000;
  logic [15:0] conv_b = 16'h0000;
  logic conv_valid = 1'b0;
  logic frame_req = 1'b0;
  logic frame_start, sclk_pin, word_valid, parallel_mode;
  logic ready_out, strobe_out;
  logic [31:0] data_word, last_word;
  logic [15:0] byte_pair, last_pair;
  int n_words;
  int miscompares = 0;
  int n_checks = 0;
  logic just = 1'b0;

  // Narrow variant so alignment is visible
  aow_output_word_cfg #(.RES_BITS(14)) aow_output_word_cfg_inst (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_a(conv_a), .conv_b(conv_b), .conv_valid(conv_valid),
    .frame_start(frame_start), .sclk_pin(sclk_pin), .data_word(data_word),
    .word_valid(word_valid), .byte_pair(byte_pair),
    .parallel_mode(parallel_mode), .ready_out(ready_out),
    .strobe_out(strobe_out));
  aow_host_model aow_host_model_inst (
    .clk(clk), .reset(reset), .frame_req(frame_req),
    .word_valid(word_valid), .data_word(data_word), .byte_pair(byte_pair),
    .frame_start(frame_start), .sclk_pin(sclk_pin), .last_word(last_word),
    .last_pair(last_pair), .n_words(n_words));

  always #4 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic frame;
    @(posedge clk);
    frame_req <= 1'b1;
    @(posedge clk);
    frame_req <= 1'b0;
    repeat (2) @(posedge clk);
    // Let registered outputs settle before callers look at them
    #1;
  endtask

  task automatic send(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    conv_a <= a;
    conv_b <= b;
    conv_valid <= 1'b1;
    @(posedge clk);
    conv_valid <= 1'b0;
  endtask

  task automatic await(input int n0, input logic [31:0] exp);
    int t;
    t = 0;
    while (n_words == n0 && t < 30) begin
      @(posedge clk);
      #1;
      t++;
    end
    chk(n_words != n0, 1);
    chk(last_word, exp);
  endtask

  function automatic logic [15:0] al(input logic [15:0] v);
    return just ? {2'b00, v[13:0]} : {v[13:0], 2'b00};
  endfunction

  task automatic t_regs;
    logic [7:0] v;
    logic [7:0] msk [4] = '{8'h03, 8'h33, 8'h03, 8'h01};
    for (int i = 0; i < 4; i++) begin
      rd(4'(i + 4), v);
      chk(v, 0);
      wr(4'(i + 4), msk[i]);
      rd(4'(i + 4), v);
      chk(v, msk[i]);
      wr(4'(i + 4), 8'h00);
    end
    wr(4'h9, 8'hFF);
    rd(4'h9, v);
    chk(v, 0);
  endtask

  task automatic t_pattern;
    int n0;
    wr(4'h5, 8'h02);
    n0 = n_words;
    send(16'h0123, 16'h0456);
    await(n0, {al(16'h0123), al(16'h0456)});
    frame;
    n0 = n_words;
    send(16'h0123, 16'h0456);
    await(n0, 32'hA55A_A55A);
    wr(4'h5, 8'h01);
    frame;
    just = 1'b1;
    n0 = n_words;
    send(16'h2123, 16'h0456);
    await(n0, {al(16'h2123), al(16'h0456)});
    just = 1'b0;
  endtask

  task automatic t_bytes;
    int n0;
    logic [15:0] a;
    logic [15:0] b;
    a = al(16'h1234);
    b = al(16'h0567);
    wr(4'h2, 8'h40);
    wr(4'h5, 8'h00);
    frame;
    chk(parallel_mode, 1);
    n0 = n_words;
    send(16'h1234, 16'h0567);
    await(n0, {a, b});
    chk(last_pair, a);
    wr(4'h2, 8'h70);
    wr(4'h5, 8'h10);
    frame;
    chk(parallel_mode, 1);
    n0 = n_words;
    send(16'h1234, 16'h0567);
    await(n0, {a, b});
    chk(last_pair, {a[15:8], b[15:8]});
    wr(4'h2, 8'h00);
    frame;
    chk(parallel_mode, 0);
  endtask

  task automatic t_strobe;
    int exp [5] = '{8, 32, 16, 8, 0};
    int n;
    int n0;
    logic p;
    for (int i = 0; i < 5; i++) begin
      // Retimer modes, then a plain serial mode with no strobe
      wr(4'h2, i == 4 ? 8'h00 : (i % 2 ? 8'h30 : 8'h20));
      wr(4'h4, 8'(i % 4));
      // Ready masked for the internal clock source case
      wr(4'h5, i == 1 ? 8'h20 : 8'h00);
      frame;
      repeat (6) @(posedge clk);
      #1;
      p = strobe_out;
      n = 0;
      repeat (32) begin
        @(posedge clk);
        #1;
        n += (strobe_out !== p);
        p = strobe_out;
      end
      chk(n, exp[i]);
      n0 = n_words;
      send(16'h0011, 16'h0022);
      await(n0, {al(16'h0011), al(16'h0022)});
      chk(ready_out, i != 1);
    end
    wr(4'h5, 8'h00);
  endtask

  task automatic t_avg;
    logic [15:0] v [4] = '{16'h0001, 16'h0002, 16'h0003, 16'h0005};
    int n;
    int s;
    int n0;
    for (int d = 1; d < 4; d++) begin
      wr(4'h6, 8'(d));
      frame;
      n = d == 3 ? 4 : (d == 2 ? 2 : 1);
      s = 0;
      n0 = n_words;
      for (int k = 0; k < n; k++) begin
        send(v[k], 16'(2 * v[k]));
        s += v[k];
      end
      await(n0, {al(16'(s / n)), al(16'(2 * s / n))});
      chk(n_words, n0 + 1);
    end
  endtask

  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_pattern;
    t_bytes;
    t_strobe;
    t_avg;
    summarize;
  end

  initial begin
    #(8 * 20000);
    miscompares++;
    summarize;
  end
endmodule
